// file: hw/ptc_pkg.sv
// Package of register map, field layout and timing constants for the tick counter.
package ptc_pkg;
    // Register byte addresses on the AXI4-Lite bus.
    localparam logic [3:0] PTC_ADDR_STATUS_CONTROL = 4'h0;
    localparam logic [3:0] PTC_ADDR_TICK_COUNT = 4'h4;
    localparam logic [3:0] PTC_ADDR_MATCH_LIMIT = 4'h8;
    localparam logic [3:0] PTC_ADDR_IRQ_MASK = 4'hC;
    // Field positions in the status/control register.
    localparam int PTC_FLAG_BIT = 7;
    localparam int PTC_SRC_HI = 6;
    localparam int PTC_SRC_LO = 5;
    localparam int PTC_IRQ_EN_BIT = 4;
    localparam int PTC_DIV_HI = 3;
    localparam int PTC_DIV_LO = 0;
    // Reset values.
    localparam logic [7:0] PTC_COUNT_RESET = 8'h00;
    localparam logic [7:0] PTC_LIMIT_RESET = 8'h00;
    localparam logic [1:0] PTC_SRC_RESET = 2'h0;
    localparam logic [3:0] PTC_DIV_RESET = 4'h0;
    localparam logic PTC_MASK_RESET = 1'b0;
    // Source select encodings.
    localparam logic [1:0] PTC_SRC_LPO = 2'h0;
    localparam logic [1:0] PTC_SRC_EXT = 2'h1;
    // Divider select code that halts the prescaler.
    localparam logic [3:0] PTC_DIV_OFF = 4'h0;
    // AXI responses.
    localparam logic [1:0] PTC_RESP_OKAY = 2'h0;
    localparam logic [1:0] PTC_RESP_SLVERR = 2'h2;
    // Width of the prescaler stage, big enough for the largest ratio.
    localparam int PTC_PRE_W = 18;
endpackage : ptc_pkg

// file: hw/ptc_sync.sv
// Two flip-flop synchroniser with rising-edge pulse output for a tick source.
`timescale 1ns/1ps
module ptc_sync
    import ptc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic async_in,
    output logic rise_pulse
);
    logic meta_ff;
    logic sync_ff;
    logic prev_ff;

    // The first stage is read only by the second stage.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            prev_ff <= 1'b0;
        end
        else
        begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    // One pulse per rising edge of the source clock.
    assign rise_pulse = sync_ff & ~prev_ff;
endmodule : ptc_sync

// file: hw/ptc_top.sv
// Periodic tick counter with prescaler, match limit and AXI4-Lite registers.
// Summary of operation
// - Tick count readable, bus writes ignored.
// - Reset: stopped, limit zero, prescaler off, slow oscillator.
// - Limit write clears prescaler and counter.
// - Changed source select clears prescaler and counter.
// - Changed divider select clears prescaler and counter.
// - Divider code zero keeps counting halted.
// - Three selectable tick source clocks.
// - Source bit zero picks divider table.
// - Code one on slow source divides by eight.
// - Counter counts to limit, wraps, continues.
// - Flag sets on limit to zero wrap.
// - Zero limit flags every prescaler output.
// - Interrupt when flag, enable and mask bit set.
// - Writing one to flag clears it.
// - Writing zero no effect; reset clears controls.
// - Source code 00, 01, 1x decode.
// - Two fifteen-entry divide ratio tables.
//
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module ptc_top
    import ptc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic low_power_osc_clock,
    input wire logic external_ref_clock,
    input wire logic internal_ref_clock,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////
    // Divide ratio lookup.
    // Ratio for a divider code; zero means the prescaler is off.
    function automatic logic [PTC_PRE_W-1:0] ptc_ratio(
        input logic table_hi,
        input logic [3:0] code
    );
        logic [PTC_PRE_W-1:0] r;
        r = '0;
        unique case ({table_hi, code})
            5'h00: r = 18'h00000;
            5'h01: r = 18'h00008;
            5'h02: r = 18'h00020;
            5'h03: r = 18'h00040;
            5'h04: r = 18'h00080;
            5'h05: r = 18'h00100;
            5'h06: r = 18'h00200;
            5'h07: r = 18'h00400;
            5'h08: r = 18'h00001;
            5'h09: r = 18'h00002;
            5'h0A: r = 18'h00004;
            5'h0B: r = 18'h0000A;
            5'h0C: r = 18'h00010;
            5'h0D: r = 18'h00064;
            5'h0E: r = 18'h001F4;
            5'h0F: r = 18'h003E8;
            5'h10: r = 18'h00000;
            5'h11: r = 18'h00400;
            5'h12: r = 18'h00800;
            5'h13: r = 18'h01000;
            5'h14: r = 18'h02000;
            5'h15: r = 18'h04000;
            5'h16: r = 18'h08000;
            5'h17: r = 18'h10000;
            5'h18: r = 18'h003E8;
            5'h19: r = 18'h007D0;
            5'h1A: r = 18'h01388;
            5'h1B: r = 18'h02710;
            5'h1C: r = 18'h04E20;
            5'h1D: r = 18'h0C350;
            5'h1E: r = 18'h186A0;
            5'h1F: r = 18'h30D40;
        endcase
        return r;
    endfunction : ptc_ratio

    ////////////////////////////////////////////////////////////////////////
    // Register state.
    logic [1:0] source_select_ff;
    logic [3:0] divider_select_ff;
    logic tick_irq_enable_ff;
    logic tick_match_flag_ff;
    logic [7:0] match_limit_ff;
    logic [7:0] tick_count_ff;
    logic [PTC_PRE_W-1:0] prescale_ff;
    logic irq_mask_ff;

    ////////////////////////////////////////////////////////////////////////
    // Tick source synchronisers and selection.
    logic [2:0] src_raw;
    logic [2:0] src_rise;
    assign src_raw = {internal_ref_clock, external_ref_clock,
                      low_power_osc_clock};

    // Each source clock is brought into clk by its own synchroniser.
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_src
            ptc_sync u_sync (
                .clk(clk),
                .rst(rst),
                .async_in(src_raw[gi]),
                .rise_pulse(src_rise[gi])
            );
        end
    endgenerate

    // Upper source bit wins, so both 1x codes take the internal clock.
    logic src_tick;
    assign src_tick = source_select_ff[1] ? src_rise[2] :
                      source_select_ff[0] ? src_rise[1] :
                      src_rise[0];

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel.
    logic aw_held_ff;
    logic w_held_ff;
    logic [3:0] aw_addr_ff;
    logic [7:0] w_data_ff;
    logic w_strb0_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;

    assign s_axi_awready = !aw_held_ff && !bvalid_ff;
    assign s_axi_wready = !w_held_ff && !bvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;

    // Address and data may arrive in either order; a half that arrives alone is latched.
    logic aw_take;
    logic w_take;
    logic [3:0] wr_addr;
    logic [7:0] wr_data;
    logic wr_strb0;
    logic wr_fire;
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign wr_addr = aw_held_ff ? aw_addr_ff : s_axi_awaddr;
    assign wr_data = w_held_ff ? w_data_ff : s_axi_wdata[7:0];
    assign wr_strb0 = w_held_ff ? w_strb0_ff : s_axi_wstrb[0];
    assign wr_fire = (aw_held_ff || aw_take) && (w_held_ff || w_take);

    // Byte lane zero carries every register; other lanes are ignored.
    logic wr_en;
    logic wr_sc;
    logic wr_lim;
    logic wr_msk;
    logic wr_known;
    assign wr_en = wr_fire && wr_strb0;
    assign wr_sc = wr_en && (wr_addr == PTC_ADDR_STATUS_CONTROL);
    assign wr_lim = wr_en && (wr_addr == PTC_ADDR_MATCH_LIMIT);
    assign wr_msk = wr_en && (wr_addr == PTC_ADDR_IRQ_MASK);
    assign wr_known = wr_addr[1:0] == 2'h0;

    // Holding registers keep whichever half arrived first.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            aw_addr_ff <= 4'h0;
            w_data_ff <= 8'h00;
            w_strb0_ff <= 1'b0;
        end
        else if (wr_fire)
        begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
        end
        else
        begin
            if (aw_take)
            begin
                aw_held_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr;
            end
            if (w_take)
            begin
                w_held_ff <= 1'b1;
                w_data_ff <= s_axi_wdata[7:0];
                w_strb0_ff <= s_axi_wstrb[0];
            end
        end
    end

    // Response one cycle after both halves are in; unmapped gives SLVERR.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            bvalid_ff <= 1'b0;
            bresp_ff <= PTC_RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_known ? PTC_RESP_OKAY : PTC_RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            bvalid_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control fields and clearing conditions.
    logic [1:0] wr_src;
    logic [3:0] wr_div;
    logic src_change;
    logic div_change;
    logic restart;
    assign wr_src = wr_data[PTC_SRC_HI:PTC_SRC_LO];
    assign wr_div = wr_data[PTC_DIV_HI:PTC_DIV_LO];
    assign src_change = wr_sc && (wr_src != source_select_ff);
    assign div_change = wr_sc && (wr_div != divider_select_ff);
    // Any limit write restarts the count, whatever the value.
    assign restart = wr_lim || src_change || div_change;

    // Control bits; a write of the same value leaves them and the count.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            source_select_ff <= PTC_SRC_RESET;
            divider_select_ff <= PTC_DIV_RESET;
            tick_irq_enable_ff <= 1'b0;
            match_limit_ff <= PTC_LIMIT_RESET;
            irq_mask_ff <= PTC_MASK_RESET;
        end
        else
        begin
            if (wr_sc)
            begin
                source_select_ff <= wr_src;
                divider_select_ff <= wr_div;
                tick_irq_enable_ff <= wr_data[PTC_IRQ_EN_BIT];
            end
            if (wr_lim)
            begin
                match_limit_ff <= wr_data;
            end
            if (wr_msk)
            begin
                irq_mask_ff <= wr_data[0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Prescaler and tick counter.
    logic [PTC_PRE_W-1:0] ratio;
    logic run;
    logic pre_out;
    logic wrap;
    assign ratio = ptc_ratio(source_select_ff[0], divider_select_ff);
    assign run = divider_select_ff != PTC_DIV_OFF;
    // One prescaler output per ratio source edges.
    assign pre_out = run && src_tick && (prescale_ff == ratio - 18'h00001);
    // Zero limit makes every prescaler output a wrap.
    assign wrap = pre_out && (tick_count_ff == match_limit_ff);

    // Counter steps only on prescaler output and clears on restart or halt, never loads bus data.
    always_ff @(posedge clk)
    begin
        if (rst || restart || !run)
        begin
            prescale_ff <= '0;
            tick_count_ff <= PTC_COUNT_RESET;
        end
        else if (src_tick)
        begin
            prescale_ff <= pre_out ? '0 : prescale_ff + 18'h00001;
            if (pre_out)
            begin
                tick_count_ff <= wrap ? PTC_COUNT_RESET
                                      : tick_count_ff + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Match flag and interrupt.
    logic flag_clr;
    assign flag_clr = wr_sc && wr_data[PTC_FLAG_BIT];

    // A wrap in the clear cycle wins so the event is kept.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            tick_match_flag_ff <= 1'b0;
        end
        else if (wrap)
        begin
            tick_match_flag_ff <= 1'b1;
        end
        else if (flag_clr)
        begin
            tick_match_flag_ff <= 1'b0;
        end
    end

    // Enable bit and mask register both gate the flag.
    assign irq = tick_match_flag_ff && tick_irq_enable_ff
                 && irq_mask_ff;

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel.
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic [7:0] sc_view;
    logic [7:0] rd_byte;
    logic rd_known;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign sc_view = {tick_match_flag_ff, source_select_ff,
                      tick_irq_enable_ff, divider_select_ff};
    assign rd_known = s_axi_araddr[1:0] == 2'h0;
    assign rd_byte =
        (s_axi_araddr == PTC_ADDR_STATUS_CONTROL) ? sc_view :
        (s_axi_araddr == PTC_ADDR_TICK_COUNT) ? tick_count_ff :
        (s_axi_araddr == PTC_ADDR_MATCH_LIMIT) ? match_limit_ff :
        (s_axi_araddr == PTC_ADDR_IRQ_MASK) ? {7'h00, irq_mask_ff} :
        8'h00;

    // Read data is captured whole in one clk edge, so it never tears.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= PTC_RESP_OKAY;
        end
        else if (s_axi_arvalid && !rvalid_ff)
        begin
            rvalid_ff <= 1'b1;
            rdata_ff <= {24'h000000, rd_byte};
            rresp_ff <= rd_known ? PTC_RESP_OKAY : PTC_RESP_SLVERR;
        end
        else if (s_axi_rready)
        begin
            rvalid_ff <= 1'b0;
        end
    end
endmodule : ptc_top

// file: dv/ptc_props.sv
// Concurrent checks on the tick counter's bus and interrupt ports.
`timescale 1ns/1ps
module ptc_props
    import ptc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////
    // Handshake words for a write whose address and data are taken in one cycle, and a read being taken.
    wire logic wr_fire = s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready;
    wire logic ar_fire = s_axi_arvalid && s_axi_arready;
    ////////////////////////////////////////////////////////////////////////
    // Reset must silence responses and the interrupt on the next edge.
    reset_quiet_a: assert property (disable iff (1'b0) rst |=>
        !s_axi_bvalid && !s_axi_rvalid && !irq) else $error("busy after reset");
    rd_answer_a: assert property (ar_fire |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while answering");
    wr_answer_a: assert property (wr_fire |=> s_axi_bvalid)
        else $error("write not answered next cycle");
    wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write resp moved");
    wr_block_a: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready) else $error("write taken early");
    // The count reads back as one byte with a clean upper word.
    count_read_a: assert property (ar_fire &&
        s_axi_araddr == PTC_ADDR_TICK_COUNT |=> s_axi_rdata[31:8] == 24'h0
        && s_axi_rresp == PTC_RESP_OKAY) else $error("bad count read");
    bad_addr_a: assert property (ar_fire && s_axi_araddr[1:0] != 2'h0 |=>
        s_axi_rresp == PTC_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unaligned read not refused");
    // Clearing the mask bit must drop the request at once.
    mask_off_a: assert property (wr_fire &&
        s_axi_awaddr == PTC_ADDR_IRQ_MASK && s_axi_wstrb[0] &&
        !s_axi_wdata[0] |=> !irq) else $error("irq survives mask");
    wr_seen_c: cover property (wr_fire);
    rd_seen_c: cover property (ar_fire);
    irq_rise_c: cover property ($rose(irq));
endmodule : ptc_props
bind ptc_top ptc_props u_props (.clk(clk), .rst(rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .irq(irq));

// file: dv/tb_periodic_tick_counter.sv
// Self-checking bench for the tick counter over its register bus.
`timescale 1ns/1ps
module tb_periodic_tick_counter;
    import ptc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] pins = 3'h0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, v;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, r;
    int fails = 0, compares = 0, cycles = 0;
    logic [1:0] ts [7] = '{2'h0, 2'h0, 2'h2, 2'h1, 2'h3, 2'h0, 2'h0};
    logic [3:0] td [7] = '{4'h1, 4'h8, 4'h9, 4'h1, 4'h1, 4'hC, 4'hB};
    int tr [7] = '{8, 1, 2, 1024, 1024, 16, 10};
    ptc_top uut (.clk(clk), .rst(rst), .low_power_osc_clock(pins[0]),
        .external_ref_clock(pins[1]), .internal_ref_clock(pins[2]),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));
    ////////////////////////////////////////////////////////////////////////
    // 125 MHz clock and a cycle limit that cuts a hang short.
    always #4 clk = ~clk;
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            fails++;
            print_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Comparison, verdict and register image helpers.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask : chk
    task automatic print_verdict();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict
    // Control word with the enable bit set and the flag bit left at zero.
    function automatic logic [31:0] ctl(input logic [1:0] s,
        input logic [3:0] d);
        return {25'h0, s, 1'b1, d};
    endfunction : ctl
    ////////////////////////////////////////////////////////////////////////
    // Bus tasks: each valid stands until the rising edge that samples its
    // ready high, and the answer is taken at the edge that samples it valid.
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end
        while (!bvalid);
        r = bresp;
        bready <= 1'b0;
        chk(r, PTC_RESP_OKAY);
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arready)
                arvalid <= 1'b0;
        end
        while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd
    task automatic rdchk(input logic [3:0] a, input logic [31:0] e,
        input logic [1:0] er);
        rd(a, v);
        chk(v, e);
        chk(r, er);
    endtask : rdchk
    task automatic flagchk(input logic e);
        rd(PTC_ADDR_STATUS_CONTROL, v);
        chk(v[PTC_FLAG_BIT], e);
    endtask : flagchk
    task automatic irqchk(input logic e);
        @(negedge clk);
        chk(irq, e);
    endtask : irqchk
    // Source edges last three cycles each way, so the synchroniser sees all.
    task automatic pulse(input int pin, input int n);
        repeat (n)
        begin
            @(posedge clk);
            pins[pin] <= 1'b1;
            repeat (3) @(posedge clk);
            pins[pin] <= 1'b0;
            repeat (2) @(posedge clk);
        end
        repeat (6) @(posedge clk);
    endtask : pulse
    ////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdchk(PTC_ADDR_STATUS_CONTROL, 32'h0, PTC_RESP_OKAY);
        rdchk(PTC_ADDR_TICK_COUNT, 32'h0, PTC_RESP_OKAY);
        rdchk(PTC_ADDR_MATCH_LIMIT, 32'h0, PTC_RESP_OKAY);
        rdchk(PTC_ADDR_IRQ_MASK, 32'h0, PTC_RESP_OKAY);
        rdchk(4'h2, 32'h0, PTC_RESP_SLVERR);
        pulse(0, 16);
        rdchk(PTC_ADDR_TICK_COUNT, 32'h0, PTC_RESP_OKAY);
        wr(PTC_ADDR_IRQ_MASK, 32'h1);
        wr(PTC_ADDR_MATCH_LIMIT, 32'h3);
        wr(PTC_ADDR_STATUS_CONTROL, ctl(2'h0, 4'h1));
        pulse(0, 24);
        rdchk(PTC_ADDR_TICK_COUNT, 32'h3, PTC_RESP_OKAY);
        irqchk(1'b0);
        pulse(0, 8);
        rdchk(PTC_ADDR_TICK_COUNT, 32'h0, PTC_RESP_OKAY);
        flagchk(1'b1);
        irqchk(1'b1);
        wr(PTC_ADDR_TICK_COUNT, 32'h55);
        rdchk(PTC_ADDR_TICK_COUNT, 32'h0, PTC_RESP_OKAY);
        wr(PTC_ADDR_IRQ_MASK, 32'h0);
        irqchk(1'b0);
        wr(PTC_ADDR_IRQ_MASK, 32'h1);
        wr(PTC_ADDR_STATUS_CONTROL, ctl(2'h0, 4'h1));
        flagchk(1'b1);
        wr(PTC_ADDR_STATUS_CONTROL, 32'h80 | ctl(2'h0, 4'h1));
        flagchk(1'b0);
        irqchk(1'b0);
        pulse(1, 8);
        rdchk(PTC_ADDR_TICK_COUNT, 32'h0, PTC_RESP_OKAY);
        pulse(0, 8);
        rdchk(PTC_ADDR_TICK_COUNT, 32'h1, PTC_RESP_OKAY);
        wr(PTC_ADDR_STATUS_CONTROL, ctl(2'h0, 4'h1));
        rdchk(PTC_ADDR_TICK_COUNT, 32'h1, PTC_RESP_OKAY);
        wr(PTC_ADDR_MATCH_LIMIT, 32'h3);
        rdchk(PTC_ADDR_TICK_COUNT, 32'h0, PTC_RESP_OKAY);
        pulse(0, 8);
        wr(PTC_ADDR_STATUS_CONTROL, ctl(2'h0, 4'h2));
        rdchk(PTC_ADDR_TICK_COUNT, 32'h0, PTC_RESP_OKAY);
        pulse(0, 32);
        wr(PTC_ADDR_STATUS_CONTROL, ctl(2'h1, 4'h2));
        rdchk(PTC_ADDR_TICK_COUNT, 32'h0, PTC_RESP_OKAY);
        // Each entry changes the setting, so counting restarts from zero.
        for (int i = 0; i < 7; i++)
        begin
            wr(PTC_ADDR_STATUS_CONTROL, ctl(ts[i], td[i]));
            pulse(ts[i][1] ? 2 : int'(ts[i][0]), tr[i] - 1);
            rdchk(PTC_ADDR_TICK_COUNT, 32'h0, PTC_RESP_OKAY);
            pulse(ts[i][1] ? 2 : int'(ts[i][0]), 1);
            rdchk(PTC_ADDR_TICK_COUNT, 32'h1, PTC_RESP_OKAY);
        end
        wr(PTC_ADDR_MATCH_LIMIT, 32'h0);
        wr(PTC_ADDR_STATUS_CONTROL, 32'h80 | ctl(2'h0, 4'h8));
        pulse(0, 1);
        flagchk(1'b1);
        rdchk(PTC_ADDR_TICK_COUNT, 32'h0, PTC_RESP_OKAY);
        wr(PTC_ADDR_STATUS_CONTROL, 32'h80 | ctl(2'h0, 4'h8));
        repeat (20) @(posedge clk);
        flagchk(1'b0);
        pulse(0, 1);
        flagchk(1'b1);
        wr(PTC_ADDR_MATCH_LIMIT, 32'h5A);
        rdchk(PTC_ADDR_MATCH_LIMIT, 32'h5A, PTC_RESP_OKAY);
        wr(PTC_ADDR_STATUS_CONTROL, ctl(2'h0, 4'h0));
        pulse(0, 16);
        rdchk(PTC_ADDR_TICK_COUNT, 32'h0, PTC_RESP_OKAY);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdchk(PTC_ADDR_STATUS_CONTROL, 32'h0, PTC_RESP_OKAY);
        rdchk(PTC_ADDR_MATCH_LIMIT, 32'h0, PTC_RESP_OKAY);
        rdchk(PTC_ADDR_IRQ_MASK, 32'h0, PTC_RESP_OKAY);
        irqchk(1'b0);
        print_verdict();
    end
endmodule : tb_periodic_tick_counter
